// *** rtl/rcd_regs.svh ***
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH
`define ADDR_W 16
`define BANK_W 3
`define CS_W 4
`define WORD_W 4
`define WORD_COUNT 16
`define WORD_RESET 4'h0
`define VENDOR_RESET 4'h0
`define VENDOR_IDX_A 4'h6
`define VENDOR_IDX_B 4'h7
`define HOLD_3T 2'h2
`define MRS_WINDOW 2'h3
`define INV_ADDR_MASK 16'hEBF8
`define INV_BANK_MASK 3'h7
`define HIGH_ADDR_MASK 16'hFFE0
`define CS_NONE 4'hF
`define IDX_GLOBAL 4'h0
`define IDX_TIMING 4'h2
`define IDX_POWER 4'h9
`define IDX_SPEED 4'hA
`endif

// *** rtl/rcd_pkg.sv ***
package rcd_pkg;
    typedef enum logic [1:0] {CMD_IDLE, CMD_NORMAL, CMD_MRS, CMD_WORD} cmd_kind_t;
    typedef logic [3:0] word_t;
endpackage : rcd_pkg

// *** rtl/rcd_bus_if.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"
interface rcd_bus_if;
    logic [`CS_W-1:0] chip_select_in_n;
    logic row_strobe_in_n;
    logic column_strobe_in_n;
    logic write_enable_in_n;
    logic [`ADDR_W-1:0] addr_in;
    logic [`BANK_W-1:0] bank_addr_in;
    logic [1:0] clock_enable_in;
    logic [1:0] termination_in;
    logic parity_in;
    logic quad_select_enable_n;
    logic parity_error_out_n;
    modport device (
        input chip_select_in_n, row_strobe_in_n, column_strobe_in_n, write_enable_in_n,
        input addr_in, bank_addr_in, clock_enable_in, termination_in, parity_in,
        input quad_select_enable_n,
        output parity_error_out_n
    );
    modport host (
        output chip_select_in_n, row_strobe_in_n, column_strobe_in_n, write_enable_in_n,
        output addr_in, bank_addr_in, clock_enable_in, termination_in, parity_in,
        output quad_select_enable_n,
        input parity_error_out_n
    );
endinterface : rcd_bus_if

// *** rtl/rcd_word_file.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"
module rcd_word_file (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic write_en,
    input wire logic [3:0] index,
    input wire rcd_pkg::word_t data,
    output rcd_pkg::word_t words [`WORD_COUNT]
);
    // Words hold with no clock edges; nothing else touches them
    genvar i;
    generate
        for (i = 0; i < `WORD_COUNT; i++)
        begin : g_word
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                begin
                    if (4'(i) == `VENDOR_IDX_A || 4'(i) == `VENDOR_IDX_B)
                        words[i] <= `VENDOR_RESET;
                    else
                        words[i] <= `WORD_RESET;
                end
                else if (write_en && index == 4'(i))
                    words[i] <= data;
            end
        end
    endgenerate
endmodule : rcd_word_file

// *** rtl/rcd_device.sv ***
// What this block does
// - Inversion on after reset release
// - Inverted B outputs complement selected A bits
// - Inversion off: B equals A
// - MRS detect suspends inversion
// - MRS chip select delayed one clock
// - 3T holds command/address three cycles, cut short if a word access clears the hold
// - Host spaces MRS commands three clocks
// - Inversion returns three clocks after MRS
// - Two-select mode: both selects means word access
// - Quad mode: pairs 2,3 or all four
// - Host never asserts three selects
// - Word access holds outputs, selects high unless a delayed MRS select is due
// - Sixteen 4-bit words, index and data fields
// - Host keeps high address low on word accesses, CKE high
// - Word access ignores termination; strobes enter only the parity check
// - Parity mismatch flags error, drops write
// - Word writes accepted at any frequency
// - Host adds no delay after words; only MRS commands are spaced
// - Host keeps selects high during settling
// - Reset restores words, vendor words chosen
// - Stopped clock keeps word values
// - Index is bank2 then addr 2..0
`timescale 1ns/1ps
`include "rcd_regs.svh"
module rcd_device (
    input wire logic clk,
    input wire logic reset_n,
    rcd_bus_if.device bus,
    output logic [`CS_W-1:0] chip_select_out_n,
    output logic row_strobe_out_n,
    output logic column_strobe_out_n,
    output logic write_enable_out_n,
    output logic [`ADDR_W-1:0] a_side_addr_out,
    output logic [`BANK_W-1:0] a_side_bank_out,
    output logic [`ADDR_W-1:0] b_side_addr_out,
    output logic [`BANK_W-1:0] b_side_bank_out,
    output logic [1:0] clock_enable_out,
    output logic [1:0] termination_out,
    output logic inversion_active,
    output rcd_pkg::word_t global_features_word,
    output rcd_pkg::word_t timing_word,
    output rcd_pkg::word_t power_saving_word,
    output rcd_pkg::word_t operating_speed_word
);
    function automatic logic [1:0] low_count(input logic [3:0] cs);
        low_count = 2'(!cs[0]) + 2'(!cs[1]) + 2'(!cs[2]) + 2'(!cs[3]);
    endfunction : low_count

    rcd_pkg::cmd_kind_t kind;
    logic [`CS_W-1:0] cs_eff;
    logic quad;
    logic one_select;
    logic word_access;
    logic parity_ok;
    logic write_ok;
    logic [3:0] word_index;
    rcd_pkg::word_t word_data;
    rcd_pkg::word_t words [`WORD_COUNT];
    logic [1:0] hold_count;
    logic [1:0] mrs_count;
    logic [`CS_W-1:0] mrs_cs;
    logic mrs_cs_pending;

    assign quad = !bus.quad_select_enable_n;
    assign cs_eff = quad ? bus.chip_select_in_n : {2'b11, bus.chip_select_in_n[1:0]};
    assign one_select = (cs_eff != `CS_NONE) && (low_count(cs_eff) == 2'h1);
    assign word_access = quad ?
        ((cs_eff[3:2] == 2'b00 && cs_eff[1:0] == 2'b11) || cs_eff == 4'h0)
        : (cs_eff[1:0] == 2'b00);
    assign parity_ok = ~^{bus.addr_in, bus.bank_addr_in, bus.row_strobe_in_n,
        bus.column_strobe_in_n, bus.write_enable_in_n, bus.parity_in};
    assign word_index = {bus.bank_addr_in[2], bus.addr_in[2:0]};
    assign word_data = {bus.bank_addr_in[1:0], bus.addr_in[4:3]};
    // Termination takes no part in the write decision; strobes count only through parity
    assign write_ok = word_access && parity_ok;

    always_comb
    begin
        if (word_access)
            kind = rcd_pkg::CMD_WORD;
        else if (one_select && !bus.row_strobe_in_n == 1'b1 && !bus.column_strobe_in_n
            && !bus.write_enable_in_n)
            kind = rcd_pkg::CMD_MRS;
        else if (one_select)
            kind = rcd_pkg::CMD_NORMAL;
        else
            kind = rcd_pkg::CMD_IDLE;
    end

    rcd_word_file words_u (
        .clk(clk),
        .reset_n(reset_n),
        .write_en(write_ok),
        .index(word_index),
        .data(word_data),
        .words(words)
    );
    assign global_features_word = words[`IDX_GLOBAL];
    assign timing_word = words[`IDX_TIMING];
    assign power_saving_word = words[`IDX_POWER];
    assign operating_speed_word = words[`IDX_SPEED];

    // Parity error flag, low active, per word write
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            bus.parity_error_out_n <= 1'b1;
        else
            bus.parity_error_out_n <= !(word_access && !parity_ok);
    end

    // Inversion window after MRS
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mrs_count <= 2'h0;
        else if (kind == rcd_pkg::CMD_MRS)
            mrs_count <= `MRS_WINDOW;
        else if (mrs_count != 2'h0)
            mrs_count <= mrs_count - 2'h1;
    end
    assign inversion_active = (mrs_count == 2'h0);

    // Command and address registers with 3T hold
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            hold_count <= 2'h0;
            row_strobe_out_n <= 1'b1;
            column_strobe_out_n <= 1'b1;
            write_enable_out_n <= 1'b1;
            a_side_addr_out <= '0;
            a_side_bank_out <= '0;
            clock_enable_out <= 2'b00;
            termination_out <= 2'b00;
        end
        else if (kind == rcd_pkg::CMD_WORD)
            hold_count <= 2'h0;
        else if (kind == rcd_pkg::CMD_MRS)
        begin
            hold_count <= `HOLD_3T;
            row_strobe_out_n <= bus.row_strobe_in_n;
            column_strobe_out_n <= bus.column_strobe_in_n;
            write_enable_out_n <= bus.write_enable_in_n;
            a_side_addr_out <= bus.addr_in;
            a_side_bank_out <= bus.bank_addr_in;
            clock_enable_out <= bus.clock_enable_in;
            termination_out <= bus.termination_in;
        end
        else if (hold_count != 2'h0)
            hold_count <= hold_count - 2'h1;
        else
        begin
            row_strobe_out_n <= bus.row_strobe_in_n;
            column_strobe_out_n <= bus.column_strobe_in_n;
            write_enable_out_n <= bus.write_enable_in_n;
            a_side_addr_out <= bus.addr_in;
            a_side_bank_out <= bus.bank_addr_in;
            clock_enable_out <= bus.clock_enable_in;
            termination_out <= bus.termination_in;
        end
    end

    // B side follows A, complemented on selected bits while inverting
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            b_side_addr_out <= '0;
            b_side_bank_out <= '0;
        end
        else if (kind == rcd_pkg::CMD_WORD)
        begin
            b_side_addr_out <= b_side_addr_out;
            b_side_bank_out <= b_side_bank_out;
        end
        else if (kind == rcd_pkg::CMD_MRS || hold_count == 2'h0)
        begin
            if (kind != rcd_pkg::CMD_MRS && inversion_active && mrs_count == 2'h0)
            begin
                b_side_addr_out <= bus.addr_in ^ `INV_ADDR_MASK;
                b_side_bank_out <= bus.bank_addr_in ^ `INV_BANK_MASK;
            end
            else
            begin
                b_side_addr_out <= bus.addr_in;
                b_side_bank_out <= bus.bank_addr_in;
            end
        end
    end

    // Chip selects: MRS select one clock late, high during word access unless the delayed MRS select is due
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            chip_select_out_n <= `CS_NONE;
            mrs_cs <= `CS_NONE;
            mrs_cs_pending <= 1'b0;
        end
        else
        begin
            mrs_cs_pending <= (kind == rcd_pkg::CMD_MRS);
            mrs_cs <= cs_eff;
            if (mrs_cs_pending)
                chip_select_out_n <= mrs_cs;
            else if (kind == rcd_pkg::CMD_NORMAL)
                chip_select_out_n <= cs_eff;
            else
                chip_select_out_n <= `CS_NONE;
        end
    end
endmodule : rcd_device

// *** rtl/rcd_host.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"
module rcd_host (
    input wire logic clk,
    input wire logic reset_n,
    rcd_bus_if.host bus,
    input wire logic quad_mode,
    input wire logic cmd_valid,
    input wire logic cmd_is_word,
    input wire logic [`CS_W-1:0] cmd_cs_n,
    input wire logic [2:0] cmd_ras_cas_we_n,
    input wire logic [`ADDR_W-1:0] cmd_addr,
    input wire logic [`BANK_W-1:0] cmd_bank,
    input wire logic cmd_bad_parity,
    output logic cmd_ready,
    output logic parity_error_seen
);
    logic [1:0] mrs_gap;
    logic is_mrs;
    logic [`CS_W-1:0] cs_legal;

    assign is_mrs = !cmd_is_word && cmd_ras_cas_we_n == 3'b000;
    assign cmd_ready = !(is_mrs && mrs_gap != 2'h0);
    // Three-low patterns are never sent
    assign cs_legal = (cmd_cs_n == 4'h1 || cmd_cs_n == 4'h2 || cmd_cs_n == 4'h4
        || cmd_cs_n == 4'h8) ? `CS_NONE : cmd_cs_n;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            mrs_gap <= 2'h0;
        else if (cmd_valid && cmd_ready && is_mrs)
            mrs_gap <= `HOLD_3T;
        else if (mrs_gap != 2'h0)
            mrs_gap <= mrs_gap - 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bus.chip_select_in_n <= `CS_NONE;
            {bus.row_strobe_in_n, bus.column_strobe_in_n, bus.write_enable_in_n} <= 3'b111;
            bus.addr_in <= '0;
            bus.bank_addr_in <= '0;
            bus.clock_enable_in <= 2'b00;
            bus.termination_in <= 2'b00;
            bus.parity_in <= 1'b1;
            bus.quad_select_enable_n <= 1'b1;
            parity_error_seen <= 1'b0;
        end
        else
        begin
            bus.quad_select_enable_n <= !quad_mode;
            bus.clock_enable_in <= 2'b11;
            parity_error_seen <= parity_error_seen || !bus.parity_error_out_n;
            if (cmd_valid && cmd_ready)
            begin
                bus.chip_select_in_n <= quad_mode ? cs_legal : {2'b11, cmd_cs_n[1:0]};
                {bus.row_strobe_in_n, bus.column_strobe_in_n, bus.write_enable_in_n}
                    <= cmd_ras_cas_we_n;
                bus.addr_in <= cmd_is_word ? (cmd_addr & ~`HIGH_ADDR_MASK) : cmd_addr;
                bus.bank_addr_in <= cmd_bank;
                // Deliberate parity flip for error injection
                bus.parity_in <= cmd_bad_parity
                    ^ (^{(cmd_is_word ? (cmd_addr & ~`HIGH_ADDR_MASK) : cmd_addr),
                    cmd_bank, cmd_ras_cas_we_n});
            end
            else
                bus.chip_select_in_n <= `CS_NONE;
        end
    end
endmodule : rcd_host

// *** sim/rcd_checker_asserts.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"
module rcd_checker_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [`CS_W-1:0] chip_select_in_n,
    input wire logic row_strobe_in_n,
    input wire logic column_strobe_in_n,
    input wire logic write_enable_in_n,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [1:0] clock_enable_in,
    input wire logic quad_select_enable_n,
    input wire logic [`CS_W-1:0] chip_select_out_n,
    input wire logic [`ADDR_W-1:0] a_side_addr_out,
    input wire logic [`ADDR_W-1:0] b_side_addr_out,
    input wire logic inversion_active
);
    logic strobes_low;
    logic one_sel;
    logic mrs;
    logic word;
    assign strobes_low = !row_strobe_in_n && !column_strobe_in_n && !write_enable_in_n;
    assign one_sel = $countones(~chip_select_in_n) == 1;
    assign mrs = strobes_low && one_sel;
    assign word = quad_select_enable_n ? (chip_select_in_n[1:0] == 2'h0)
        : (chip_select_in_n == 4'h3 || chip_select_in_n == 4'h0);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_inv_reset; !$past(reset_n) |-> inversion_active; endproperty
    a_inv_reset: assert property (p_inv_reset) else $error("inversion off after reset");
    property p_inv_b;
        $past(one_sel && !strobes_low && inversion_active) && inversion_active
            |-> b_side_addr_out == (a_side_addr_out ^ `INV_ADDR_MASK);
    endproperty
    a_inv_b: assert property (p_inv_b) else $error("b side not inverted");
    property p_mrs_same; $past(mrs) |-> b_side_addr_out == a_side_addr_out; endproperty
    a_mrs_same: assert property (p_mrs_same) else $error("b side differs in mrs");
    property p_mrs_off; mrs |=> !inversion_active [*3]; endproperty
    a_mrs_off: assert property (p_mrs_off) else $error("inversion not suspended");
    property p_mrs_cs; mrs |-> ##2 chip_select_out_n == $past(chip_select_in_n, 2); endproperty
    a_mrs_cs: assert property (p_mrs_cs) else $error("mrs select not delayed");
    property p_hold; mrs |-> ##2 $stable(a_side_addr_out) [*2]; endproperty
    a_hold: assert property (p_hold) else $error("address not held");
    property p_gap; mrs |=> !mrs [*2]; endproperty
    a_gap: assert property (p_gap) else $error("mrs too close");
    property p_back; mrs ##1 !mrs [*4] |-> inversion_active; endproperty
    a_back: assert property (p_back) else $error("inversion not restored");
    property p_three; !quad_select_enable_n |-> $countones(chip_select_in_n) != 1; endproperty
    a_three: assert property (p_three) else $error("three selects asserted");
    property p_word_hold;
        word |=> chip_select_out_n == `CS_NONE && $stable(a_side_addr_out);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word access moved outputs");
    property p_word_addr;
        word |-> (addr_in & `HIGH_ADDR_MASK) == 16'h0000 && |clock_enable_in;
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("bad word access fields");
    property p_pass;
        one_sel && !strobes_low && inversion_active |=> a_side_addr_out == $past(addr_in);
    endproperty
    a_pass: assert property (p_pass) else $error("command not registered");
    c_mrs: cover property (mrs ##4 inversion_active);
    c_word_quad: cover property (word && !quad_select_enable_n);
    c_word_two: cover property (word && quad_select_enable_n);
endmodule : rcd_checker_asserts

// *** sim/test_rcd_mrs_and_control_word_access.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"
module test_rcd_mrs_and_control_word_access;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic quad_mode = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_is_word = 1'b0;
    logic [3:0] cmd_cs_n = 4'hF;
    logic [2:0] cmd_ras_cas_we_n = 3'h7;
    logic [15:0] cmd_addr = 16'h0000;
    logic [2:0] cmd_bank = 3'h0;
    logic cmd_bad_parity = 1'b0;
    logic [2:0] rcw_out;
    logic [1:0] cke_out;
    logic [1:0] term_out;
    logic cmd_ready, parity_error_seen, inversion_active;
    logic [3:0] cs_out_n;
    logic [15:0] a_addr, b_addr;
    logic [2:0] a_bank, b_bank;
    rcd_pkg::word_t w_glob, w_tim, w_pwr, w_spd;
    int failures = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    rcd_bus_if rcd_bus_if_inst ();
    rcd_host rcd_host_inst (.clk(clk), .reset_n(reset_n), .bus(rcd_bus_if_inst),
        .quad_mode(quad_mode), .cmd_valid(cmd_valid), .cmd_is_word(cmd_is_word),
        .cmd_bad_parity(cmd_bad_parity),
        .cmd_cs_n(cmd_cs_n), .cmd_ras_cas_we_n(cmd_ras_cas_we_n), .cmd_addr(cmd_addr),
        .cmd_bank(cmd_bank), .cmd_ready(cmd_ready), .parity_error_seen(parity_error_seen));
    rcd_device rcd_device_inst (.clk(clk), .reset_n(reset_n), .bus(rcd_bus_if_inst),
        .chip_select_out_n(cs_out_n), .row_strobe_out_n(rcw_out[2]),
        .column_strobe_out_n(rcw_out[1]), .write_enable_out_n(rcw_out[0]),
        .a_side_addr_out(a_addr), .a_side_bank_out(a_bank),
        .b_side_addr_out(b_addr), .b_side_bank_out(b_bank), .clock_enable_out(cke_out),
        .termination_out(term_out), .inversion_active(inversion_active),
        .global_features_word(w_glob), .timing_word(w_tim),
        .power_saving_word(w_pwr), .operating_speed_word(w_spd));
    rcd_checker_asserts rcd_checker_asserts_inst (.clk(clk), .reset_n(reset_n),
        .chip_select_in_n(rcd_bus_if_inst.chip_select_in_n),
        .row_strobe_in_n(rcd_bus_if_inst.row_strobe_in_n),
        .column_strobe_in_n(rcd_bus_if_inst.column_strobe_in_n),
        .write_enable_in_n(rcd_bus_if_inst.write_enable_in_n),
        .addr_in(rcd_bus_if_inst.addr_in), .clock_enable_in(rcd_bus_if_inst.clock_enable_in),
        .quad_select_enable_n(rcd_bus_if_inst.quad_select_enable_n),
        .chip_select_out_n(cs_out_n), .a_side_addr_out(a_addr), .b_side_addr_out(b_addr),
        .inversion_active(inversion_active));

    task print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task at(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : at

    task send(input logic [3:0] cs, input logic [2:0] rcw, input logic [15:0] a,
        input logic [2:0] b, input logic w);
        int i;
        @(posedge clk);
        cmd_cs_n <= cs;
        cmd_ras_cas_we_n <= rcw;
        cmd_addr <= a;
        cmd_bank <= b;
        cmd_is_word <= w;
        cmd_valid <= 1'b1;
        i = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && i < 20)
        begin
            @(negedge clk);
            i++;
        end
        if (i == 20)
        begin
            failures++;
            $display("[FAIL] %0t host never ready", $time);
            print_verdict();
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send

    task wr(input logic [3:0] ix, input logic [3:0] d, input logic [3:0] cs);
        send(cs, 3'h0, {11'h000, d[1:0], ix[2:0]}, {ix[3], d[3:2]}, 1'b1);
    endtask : wr

    task do_reset;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        at(1);
        chk(inversion_active === 1'b1, "inversion off");
        chk({w_glob, w_tim, w_pwr, w_spd} === 16'h0000, "words not cleared");
        $display("reset test done");
    endtask : do_reset

    task t_invert;
        send(4'hE, 3'h5, 16'hFFFF, 3'h5, 1'b0);
        at(1);
        chk(a_addr === 16'hFFFF && b_addr === (16'hFFFF ^ `INV_ADDR_MASK), "addr");
        chk(a_bank === 3'h5 && b_bank === 3'h2 && cs_out_n === 4'hE, "bank or select");
        chk(rcw_out === 3'h5 && cke_out === 2'h3 && term_out === 2'h0, "strobes");
        $display("inversion test done");
    endtask : t_invert

    task t_mrs;
        send(4'hD, 3'h0, 16'hFFFF, 3'h3, 1'b0);
        at(1);
        chk(inversion_active === 1'b0 && b_addr === 16'hFFFF, "mrs inversion");
        chk(cs_out_n === 4'hF && b_bank === 3'h3, "select too early");
        at(1);
        chk(cs_out_n === 4'hD && a_addr === 16'hFFFF, "delayed select");
        at(1);
        chk(cs_out_n === 4'hF && a_addr === 16'hFFFF, "third hold cycle");
        at(1);
        chk(inversion_active === 1'b1, "inversion not back");
        send(4'hE, 3'h0, 16'h0123, 3'h1, 1'b0);
        send(4'hE, 3'h0, 16'h0456, 3'h2, 1'b0);
        at(3);
        chk(inversion_active === 1'b0, "second mrs");
        at(2);
        $display("mrs test done");
    endtask : t_mrs

    task t_words;
        wr(4'h0, 4'hA, 4'hC);
        wr(4'h2, 4'h5, 4'hC);
        quad_mode <= 1'b1;
        wr(4'h9, 4'hC, 4'h3);
        wr(4'hA, 4'h3, 4'h0);
        at(2);
        chk({w_glob, w_tim, w_pwr, w_spd} === 16'hA5C3, "word values");
        chk(cs_out_n === 4'hF && rcd_bus_if_inst.parity_error_out_n === 1'b1, "outs");
        chk(parity_error_seen === 1'b0, "parity error");
        @(posedge clk);
        cmd_bad_parity <= 1'b1;
        wr(4'h0, 4'h5, 4'h0);
        cmd_bad_parity <= 1'b0;
        at(1);
        chk(rcd_bus_if_inst.parity_error_out_n === 1'b0 && w_glob === 4'hA, "bad");
        at(1);
        chk(rcd_bus_if_inst.parity_error_out_n === 1'b1, "err stuck");
        chk(parity_error_seen === 1'b1, "err unseen");
        @(posedge clk);
        quad_mode <= 1'b0;
        $display("word test done");
    endtask : t_words

    initial
    begin
        do_reset();
        t_invert();
        t_mrs();
        t_words();
        do_reset();
        print_verdict();
    end
endmodule : test_rcd_mrs_and_control_word_access
